//--- rtl/sdsrc_pkg.sv
// Constants, register layout and types of the dark-column and skip readout controller
// Function
// - Context select bit high picks context B settings, low picks context A.
// - Context A row skip enable: 0 reads every row, 1 skips; resets to 1.
// - Context A column skip field 00/01/10/11 means skip 2x/4x/8x/16x.
// - Context A row skip field 00/01/10/11 means skip 2x/4x/8x/16x.
// - Dark column count bit 0 reads columns 4-23, 1 reads columns 4-39.
// - During binning the count bit is ignored and all forty dark columns are used.
// - Shown dark columns precede active pixels, then two idle pixel times follow.
// - Showing dark columns raises line valid by the dark column count plus 2 pixels (22 for columns 4-23), blanking shrinks equally.
// - Dark column read enable (reset 1) feeds dark columns to row noise correction.
// - Dark column readout lengthens minimum blanking but keeps row time unchanged.
// - Shown dark rows precede the window, frame valid rises earlier, rate unchanged.
// - Dark start field picks first of eight dark rows, plus internal offset 4.
// - Dark row readout reads count plus one rows each frame; count resets to 7.
// - Extra reset (reset 1) reads and resets two rows above and below the window.
// - Next row reset with short integration resets row n+1 just before row n.
package sdsrc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  SDSRC_OFS_RDMODE_A = 8'h21;
    localparam logic [7:0]  SDSRC_OFS_SHOW     = 8'h22;
    localparam logic [7:0]  SDSRC_OFS_XRESET   = 8'h24;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] SDSRC_RST_RDMODE_A = 16'h8490;
    localparam logic [15:0] SDSRC_RST_SHOW     = 16'h0107;
    localparam logic [15:0] SDSRC_RST_XRESET   = 16'h8000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SDSRC_B_BINNING    = 15;
    localparam int SDSRC_B_CSKIP_EN   = 7;
    localparam int SDSRC_B_CSKIP_LO   = 5;
    localparam int SDSRC_B_RSKIP_EN   = 4;
    localparam int SDSRC_B_RSKIP_LO   = 2;
    localparam int SDSRC_B_NDCOL      = 10;
    localparam int SDSRC_B_SHOW_DCOL  = 9;
    localparam int SDSRC_B_READ_DCOL  = 8;
    localparam int SDSRC_B_SHOW_DROW  = 7;
    localparam int SDSRC_B_DSTART_LO  = 4;
    localparam int SDSRC_B_DROW_EN    = 3;
    localparam int SDSRC_B_NDROW_LO   = 0;
    localparam int SDSRC_B_XRST_EN    = 15;
    localparam int SDSRC_B_NEXT_RST   = 14;

    // ------------------------------------------------------------
    // Counts in pixel times and rows
    // ------------------------------------------------------------
    localparam logic [11:0] SDSRC_DCOL_FIRST  = 12'h004;
    localparam logic [11:0] SDSRC_DCOL_NARROW = 12'h014;
    localparam logic [11:0] SDSRC_DCOL_WIDE   = 12'h024;
    localparam logic [11:0] SDSRC_DCOL_ALL    = 12'h028;
    localparam logic [11:0] SDSRC_DCOL_GAP    = 12'h002;
    localparam logic [11:0] SDSRC_DROW_OFS    = 12'h004;
    localparam logic [11:0] SDSRC_XRST_ROWS   = 12'h002;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } sdsrc_reg_req_t;

    typedef enum logic [2:0] {R_IDLE, R_DARK, R_XTOP, R_WIN, R_XBOT} sdsrc_rphase_t;
    typedef enum logic [1:0] {L_BLANK, L_DARK, L_GAP, L_ACT} sdsrc_lphase_t;

endpackage : sdsrc_pkg

//--- rtl/sdsrc_skip_dec.sv
// Skip field decoder giving the address step for rows or columns
`timescale 1ns/1ps
module sdsrc_skip_dec (
    input  wire logic       en,
    input  wire logic [1:0] code,
    output logic      [4:0] step
);
    // Disabled reads every address, else 2x, 4x, 8x or 16x
    assign step = en ? (5'h02 << code) : 5'h01;
endmodule : sdsrc_skip_dec

//--- rtl/sdsrc_core.sv
// Readout sequencer with skip, dark column, dark row and extra reset control
`timescale 1ns/1ps
module sdsrc_core #(
    parameter int WIN_ROWS = 1200,
    parameter int WIN_COLS = 1600,
    parameter int WIN_ROW0 = 16,
    parameter int HBLANK   = 64
) (
    input  wire logic                      CLK,
    input  wire logic                      RST,
    input  wire sdsrc_pkg::sdsrc_reg_req_t REG_REQ,
    output logic                    [15:0] REG_RDATA,
    input  wire logic                      CTX_SEL,
    input  wire logic                      FRAME_START,
    input  wire logic                      INTEG_SHORT,
    output logic                           FRAME_VALID,
    output logic                           LINE_VALID,
    output logic                    [11:0] ROW_ADDR,
    output logic                    [11:0] COL_ADDR,
    output logic                           COL_DARK,
    output logic                           NOISE_CORR_EN,
    output logic                           ROW_RST,
    output logic                    [11:0] ROW_RST_ADDR
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (HBLANK < 44 || HBLANK > 4000) begin : g_bad_hblank
        $error("HBLANK must leave room for 40 dark columns, gap and reset");
    end
    if (WIN_ROWS < 1 || WIN_COLS < 1 || WIN_ROW0 < 12 || WIN_ROW0 + WIN_ROWS > 4090) begin : g_bad_win
        $error("Window does not fit the 12-bit address space");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]              rdm_ff;
    logic [15:0]              rdm_act_ff;
    logic [15:0]              shw_ff;
    logic [15:0]              xrs_ff;
    logic                     ctx_b_ff;
    sdsrc_pkg::sdsrc_rphase_t rph_ff;
    sdsrc_pkg::sdsrc_lphase_t lph_ff;
    logic [11:0]              lc_ff;
    logic [11:0]              cc_ff;
    logic [11:0]              ri_ff;
    sdsrc_pkg::sdsrc_rphase_t nxt_rph;
    sdsrc_pkg::sdsrc_lphase_t nxt_lph;
    logic [11:0]              nxt_lc;
    logic [11:0]              nxt_cc;
    logic [11:0]              nxt_ri;
    logic                     frame_go;
    logic [15:0]              nxt_rdata;

    // Register write decode
    wire wr_rdm = REG_REQ.wr && (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_RDMODE_A);
    wire wr_shw = REG_REQ.wr && (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_SHOW);
    wire wr_xrs = REG_REQ.wr && (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_XRESET);

    // Read mux, unmapped reads return zero
    assign nxt_rdata = !REG_REQ.rd ? REG_RDATA :
                       (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_RDMODE_A) ? rdm_ff :
                       (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_SHOW)     ? shw_ff :
                       (REG_REQ.addr == sdsrc_pkg::SDSRC_OFS_XRESET)   ? xrs_ff : 16'h0000;

    // Host registers; dark and reset fields act at once
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdm_ff    <= sdsrc_pkg::SDSRC_RST_RDMODE_A;
            shw_ff    <= sdsrc_pkg::SDSRC_RST_SHOW;
            xrs_ff    <= sdsrc_pkg::SDSRC_RST_XRESET;
            REG_RDATA <= 16'h0000;
        end else begin
            if (wr_rdm) rdm_ff <= REG_REQ.wdata;
            if (wr_shw) shw_ff <= REG_REQ.wdata;
            if (wr_xrs) xrs_ff <= REG_REQ.wdata;
            REG_RDATA <= nxt_rdata;
        end
    end

    // Skip settings and context latched at frame start
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdm_act_ff <= sdsrc_pkg::SDSRC_RST_RDMODE_A;
            ctx_b_ff   <= 1'b0;
        end else if (frame_go) begin
            rdm_act_ff <= rdm_ff;
            ctx_b_ff   <= CTX_SEL;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic [4:0] cstep;
    logic [4:0] rstep;
    wire ctx_a    = !ctx_b_ff;
    wire binning  = ctx_a && rdm_act_ff[sdsrc_pkg::SDSRC_B_BINNING];
    wire cskip_en = ctx_a && rdm_act_ff[sdsrc_pkg::SDSRC_B_CSKIP_EN];
    wire rskip_en = ctx_a && rdm_act_ff[sdsrc_pkg::SDSRC_B_RSKIP_EN];

    sdsrc_skip_dec u_cskip (
        .en   (cskip_en),
        .code (rdm_act_ff[sdsrc_pkg::SDSRC_B_CSKIP_LO +: 2]),
        .step (cstep)
    );
    sdsrc_skip_dec u_rskip (
        .en   (rskip_en),
        .code (rdm_act_ff[sdsrc_pkg::SDSRC_B_RSKIP_LO +: 2]),
        .step (rstep)
    );

    // Dark column selection and line timing
    wire         rd_dark   = shw_ff[sdsrc_pkg::SDSRC_B_READ_DCOL];
    wire         show_cols = rd_dark && shw_ff[sdsrc_pkg::SDSRC_B_SHOW_DCOL];
    wire  [11:0] dark_n    = binning ? sdsrc_pkg::SDSRC_DCOL_ALL :
                             shw_ff[sdsrc_pkg::SDSRC_B_NDCOL] ? sdsrc_pkg::SDSRC_DCOL_WIDE :
                             sdsrc_pkg::SDSRC_DCOL_NARROW;
    wire  [11:0] dark_first = binning ? 12'h000 : sdsrc_pkg::SDSRC_DCOL_FIRST;
    wire  [11:0] pre_len    = rd_dark ? dark_n + sdsrc_pkg::SDSRC_DCOL_GAP : 12'h000;
    wire  [11:0] blank_len  = 12'(HBLANK) - pre_len;

    // Dark rows, extra reset and next row reset
    wire        show_rows = shw_ff[sdsrc_pkg::SDSRC_B_SHOW_DROW];
    wire        drow_en   = show_rows || shw_ff[sdsrc_pkg::SDSRC_B_DROW_EN];
    wire [11:0] dstart    = {9'h000, shw_ff[sdsrc_pkg::SDSRC_B_DSTART_LO +: 3]};
    wire [11:0] dcount    = {9'h000, shw_ff[sdsrc_pkg::SDSRC_B_NDROW_LO +: 3]};
    wire        xrst_en   = xrs_ff[sdsrc_pkg::SDSRC_B_XRST_EN];
    wire        nrr_on    = xrs_ff[sdsrc_pkg::SDSRC_B_NEXT_RST] && INTEG_SHORT && (rph_ff == sdsrc_pkg::R_WIN);

    // Row address per phase
    wire [11:0] row_addr =
        (rph_ff == sdsrc_pkg::R_DARK) ? sdsrc_pkg::SDSRC_DROW_OFS + dstart + ri_ff :
        (rph_ff == sdsrc_pkg::R_XTOP) ? 12'(WIN_ROW0) - sdsrc_pkg::SDSRC_XRST_ROWS + ri_ff :
        (rph_ff == sdsrc_pkg::R_WIN)  ? 12'(WIN_ROW0) + ri_ff :
        (rph_ff == sdsrc_pkg::R_XBOT) ? 12'(WIN_ROW0 + WIN_ROWS) + ri_ff : 12'h000;

    // Line and row ends
    wire [11:0] cc_next  = cc_ff + {7'h00, cstep};
    wire [11:0] ri_next  = ri_ff + {7'h00, rstep};
    wire        line_end = (lph_ff == sdsrc_pkg::L_ACT) && (cc_next >= 12'(WIN_COLS));
    wire        in_blank = (lph_ff == sdsrc_pkg::L_BLANK) && (rph_ff != sdsrc_pkg::R_IDLE) &&
                           (rph_ff != sdsrc_pkg::R_DARK);
    assign frame_go = (rph_ff == sdsrc_pkg::R_IDLE) && FRAME_START;
    wire        out_row  = (rph_ff == sdsrc_pkg::R_WIN) || ((rph_ff == sdsrc_pkg::R_DARK) && show_rows);

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_rph = rph_ff;
        nxt_lph = lph_ff;
        nxt_lc  = lc_ff + 12'h001;
        nxt_cc  = cc_ff;
        nxt_ri  = ri_ff;
        if (rph_ff == sdsrc_pkg::R_IDLE) begin
            nxt_lc  = 12'h000;
            nxt_lph = sdsrc_pkg::L_BLANK;
            nxt_ri  = 12'h000;
            if (FRAME_START) begin
                nxt_rph = drow_en ? sdsrc_pkg::R_DARK : xrst_en ? sdsrc_pkg::R_XTOP : sdsrc_pkg::R_WIN;
            end
        end else begin
            unique case (lph_ff)
                sdsrc_pkg::L_BLANK: begin
                    if (lc_ff >= blank_len - 12'h001) begin // Survives a shorter blank written mid-line
                        nxt_lc  = 12'h000;
                        nxt_lph = rd_dark ? sdsrc_pkg::L_DARK : sdsrc_pkg::L_ACT;
                        nxt_cc  = rd_dark ? dark_first : 12'h000;
                    end
                end
                sdsrc_pkg::L_DARK: begin
                    nxt_cc = cc_ff + 12'h001;
                    if (lc_ff >= dark_n - 12'h001) begin
                        nxt_lc  = 12'h000;
                        nxt_lph = sdsrc_pkg::L_GAP;
                    end
                end
                sdsrc_pkg::L_GAP: begin
                    if (lc_ff == sdsrc_pkg::SDSRC_DCOL_GAP - 12'h001) begin
                        nxt_lc  = 12'h000;
                        nxt_lph = sdsrc_pkg::L_ACT;
                        nxt_cc  = 12'h000;
                    end
                end
                sdsrc_pkg::L_ACT: begin
                    nxt_cc = cc_next;
                    if (line_end) begin
                        nxt_lc  = 12'h000;
                        nxt_lph = sdsrc_pkg::L_BLANK;
                        nxt_cc  = 12'h000;
                    end
                end
            endcase
            if (line_end) begin
                unique case (rph_ff)
                    sdsrc_pkg::R_DARK: begin
                        nxt_ri = ri_ff + 12'h001;
                        if (ri_ff == dcount) begin
                            nxt_ri  = 12'h000;
                            nxt_rph = xrst_en ? sdsrc_pkg::R_XTOP : sdsrc_pkg::R_WIN;
                        end
                    end
                    sdsrc_pkg::R_XTOP, sdsrc_pkg::R_XBOT: begin
                        nxt_ri = ri_ff + 12'h001;
                        if (ri_ff == sdsrc_pkg::SDSRC_XRST_ROWS - 12'h001) begin
                            nxt_ri  = 12'h000;
                            nxt_rph = (rph_ff == sdsrc_pkg::R_XTOP) ? sdsrc_pkg::R_WIN : sdsrc_pkg::R_IDLE;
                        end
                    end
                    sdsrc_pkg::R_WIN: begin
                        nxt_ri = ri_next;
                        if (ri_next >= 12'(WIN_ROWS)) begin
                            nxt_ri  = 12'h000;
                            nxt_rph = xrst_en ? sdsrc_pkg::R_XBOT : sdsrc_pkg::R_IDLE;
                        end
                    end
                    default: nxt_rph = sdsrc_pkg::R_IDLE;
                endcase
            end
        end
    end

    // Sequencer state
    always_ff @(posedge CLK) begin
        if (RST) begin
            rph_ff <= sdsrc_pkg::R_IDLE;
            lph_ff <= sdsrc_pkg::L_BLANK;
            lc_ff  <= 12'h000;
            cc_ff  <= 12'h000;
            ri_ff  <= 12'h000;
        end else begin
            rph_ff <= nxt_rph;
            lph_ff <= nxt_lph;
            lc_ff  <= nxt_lc;
            cc_ff  <= nxt_cc;
            ri_ff  <= nxt_ri;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire nxt_lv  = out_row && ((lph_ff == sdsrc_pkg::L_ACT) ||
                   (show_cols && ((lph_ff == sdsrc_pkg::L_DARK) || (lph_ff == sdsrc_pkg::L_GAP))));
    wire nxt_rst = in_blank && ((lc_ff == 12'h000) || (nrr_on && (lc_ff == 12'h001)));
    wire [11:0] nxt_rst_addr = (nrr_on && (lc_ff == 12'h000)) ? row_addr + 12'h001 : row_addr;

    always_ff @(posedge CLK) begin
        if (RST) begin
            FRAME_VALID   <= 1'b0;
            LINE_VALID    <= 1'b0;
            ROW_ADDR      <= 12'h000;
            COL_ADDR      <= 12'h000;
            COL_DARK      <= 1'b0;
            NOISE_CORR_EN <= 1'b0;
            ROW_RST       <= 1'b0;
            ROW_RST_ADDR  <= 12'h000;
        end else begin
            FRAME_VALID   <= out_row;
            LINE_VALID    <= nxt_lv;
            ROW_ADDR      <= row_addr;
            COL_ADDR      <= cc_ff;
            COL_DARK      <= (rph_ff != sdsrc_pkg::R_IDLE) && (lph_ff == sdsrc_pkg::L_DARK);
            NOISE_CORR_EN <= rd_dark;
            ROW_RST       <= nxt_rst;
            ROW_RST_ADDR  <= nxt_rst_addr;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ctx_b;
        @(posedge CLK) disable iff (RST) ctx_b_ff |-> (cstep == 5'h01 && rstep == 5'h01);
    endproperty
    a_ctx_b: assert property (p_ctx_b) else $error("Context B used context A skip");
    property p_rskip_off;
        @(posedge CLK) disable iff (RST) (ctx_a && !rdm_act_ff[sdsrc_pkg::SDSRC_B_RSKIP_EN]) |-> rstep == 5'h01;
    endproperty
    a_rskip_off: assert property (p_rskip_off) else $error("Row skip without enable");
    property p_cskip16;
        @(posedge CLK) disable iff (RST)
            (cskip_en && rdm_act_ff[6:5] == 2'b11 && lph_ff == sdsrc_pkg::L_ACT && !line_end) |=> cc_ff == $past(cc_ff) + 12'h010;
    endproperty
    a_cskip16: assert property (p_cskip16) else $error("Column skip 16x step wrong");
    property p_rskip;
        @(posedge CLK) disable iff (RST)
            (rph_ff == sdsrc_pkg::R_WIN && line_end && ri_next < 12'(WIN_ROWS)) |=> ri_ff == $past(ri_ff) + {7'h00, $past(rstep)};
    endproperty
    a_rskip: assert property (p_rskip) else $error("Row skip step wrong");
    property p_dcol20;
        @(posedge CLK) disable iff (RST)
            (rph_ff != sdsrc_pkg::R_IDLE && lph_ff == sdsrc_pkg::L_DARK && !binning && !shw_ff[sdsrc_pkg::SDSRC_B_NDCOL])
            |-> (cc_ff >= 12'h004 && cc_ff <= 12'h017);
    endproperty
    a_dcol20: assert property (p_dcol20) else $error("Dark column outside 4-23");
    property p_gap;
        @(posedge CLK) disable iff (RST)
            (lph_ff == sdsrc_pkg::L_DARK && nxt_lph == sdsrc_pkg::L_GAP) |=> (lph_ff == sdsrc_pkg::L_GAP)[*2] ##1 lph_ff == sdsrc_pkg::L_ACT;
    endproperty
    a_gap: assert property (p_gap) else $error("Idle gap not two pixels");
    property p_early_lv;
        @(posedge CLK) disable iff (RST)
            (rph_ff == sdsrc_pkg::R_WIN && show_cols && lph_ff == sdsrc_pkg::L_BLANK && nxt_lph == sdsrc_pkg::L_DARK)
            |=> ##1 LINE_VALID;
    endproperty
    a_early_lv: assert property (p_early_lv) else $error("Line valid not raised at dark columns");
    property p_drow_start;
        @(posedge CLK) disable iff (RST)
            (rph_ff == sdsrc_pkg::R_DARK && ri_ff == 12'h000) |=> ROW_ADDR == $past(dstart) + 12'h004;
    endproperty
    a_drow_start: assert property (p_drow_start) else $error("Dark row offset wrong");
    property p_noxrst;
        @(posedge CLK) disable iff (RST) (frame_go && !drow_en && !xrst_en) |=> rph_ff == sdsrc_pkg::R_WIN;
    endproperty
    a_noxrst: assert property (p_noxrst) else $error("Extra rows read while disabled");
    property p_nrr;
        @(posedge CLK) disable iff (RST)
            (in_blank && nrr_on && lc_ff == 12'h000) |=> (ROW_RST && ROW_RST_ADDR == $past(row_addr) + 12'h001)
            ##1 (ROW_RST && ROW_RST_ADDR == $past(row_addr, 2));
    endproperty
    a_nrr: assert property (p_nrr) else $error("Next row reset order wrong");
    property p_sync;
        @(posedge CLK) disable iff (RST) (rph_ff != sdsrc_pkg::R_IDLE) |=> $stable(rdm_act_ff);
    endproperty
    a_sync: assert property (p_sync) else $error("Skip settings changed mid frame");
    c_dark_rows: cover property (@(posedge CLK) disable iff (RST) rph_ff == sdsrc_pkg::R_DARK && show_rows);
    c_show_cols: cover property (@(posedge CLK) disable iff (RST) LINE_VALID && COL_DARK);
    c_xbot:      cover property (@(posedge CLK) disable iff (RST) rph_ff == sdsrc_pkg::R_XBOT);

endmodule : sdsrc_core

//--- tb/sdsrc_pix_model.sv
// Downstream pipeline model measuring lines, dark columns and row resets
`timescale 1ns/1ps
module sdsrc_pix_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic        fv,
    input  wire logic        lv,
    input  wire logic        dk,
    input  wire logic        rrst,
    input  wire logic [11:0] raddr,
    input  wire logic [11:0] caddr,
    input  wire logic [11:0] rraddr,
    output logic      [11:0] lv_len,
    output logic      [11:0] dk_len,
    output logic      [11:0] lines,
    output logic      [11:0] rsts,
    output logic      [11:0] row0,
    output logic      [11:0] idle,
    output logic      [11:0] dk_first,
    output logic      [11:0] dk_last,
    output logic      [11:0] rr_first,
    output logic      [11:0] rr_second,
    output logic      [11:0] lv_per
);
    logic        lv_d, dk_d, fv_d;
    logic [11:0] lv_run, dk_run, per_run;
    // Run lengths and event counts, cleared at each frame start
    always_ff @(posedge clk) begin
        lv_d <= lv;
        dk_d <= dk;
        fv_d <= fv;
        lv_run <= lv ? lv_run + 12'h001 : 12'h000;
        dk_run <= dk ? dk_run + 12'h001 : 12'h000;
        // Cycles from one line start to the next
        per_run <= (lv && !lv_d) ? 12'h001 : per_run + 12'h001;
        if (rst || clr) begin
            lv_len <= 12'h000;
            dk_len <= 12'h000;
            lines <= 12'h000;
            rsts <= 12'h000;
            row0 <= 12'h000;
            idle <= 12'h000;
            dk_first <= 12'h000;
            dk_last <= 12'h000;
            rr_first <= 12'h000;
            rr_second <= 12'h000;
            lv_per <= 12'h000;
        end else begin
            // Row period, dark column span and first two reset rows
            if (lv && !lv_d) lv_per <= per_run;
            if (dk && !dk_d) dk_first <= caddr;
            if (dk) dk_last <= caddr;
            if (rrst && rsts == 12'h000) rr_first <= rraddr;
            if (rrst && rsts == 12'h001) rr_second <= rraddr;
            if (lv_d && !lv) lv_len <= lv_run;
            if (dk_d && !dk) dk_len <= dk_run;
            if (lv && !lv_d) lines <= lines + 12'h001;
            if (rrst) rsts <= rsts + 12'h001;
            if (fv && !fv_d && lines == 12'h000) row0 <= raddr;
            // Quiet time, saturating, marks the frame as over
            idle <= (lv || rrst || fv) ? 12'h000 : idle + {11'h000, idle != 12'h0c8};
        end
    end
endmodule : sdsrc_pix_model

//--- tb/tb.sv
// Self-checking bench for the readout controller registers and frame sequencing
`timescale 1ns/1ps
module tb;
    logic                      CLK = 1'b0;
    logic                      RST = 1'b1;
    sdsrc_pkg::sdsrc_reg_req_t req = '0;
    logic                      ctx = 1'b0;
    logic                      fs = 1'b0;
    logic                      ishort = 1'b0;
    logic                      clr = 1'b0;
    logic               [15:0] rdata;
    logic                      fv, lv, cdark, nce, rrst;
    logic               [11:0] raddr, caddr, rraddr, lv_len, dk_len, lines, rsts, row0, idle;
    logic               [11:0] dkf, dkl, rrf, rrs, lvp;
    int                        miscompares = 0;
    int                        checks = 0;
    int                        cycles = 0;

    sdsrc_core #(.WIN_ROWS(8), .WIN_COLS(16), .WIN_ROW0(16), .HBLANK(48)) u_sdsrc_core (
        .CLK(CLK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .CTX_SEL(ctx),
        .FRAME_START(fs), .INTEG_SHORT(ishort), .FRAME_VALID(fv), .LINE_VALID(lv),
        .ROW_ADDR(raddr), .COL_ADDR(caddr), .COL_DARK(cdark), .NOISE_CORR_EN(nce),
        .ROW_RST(rrst), .ROW_RST_ADDR(rraddr));
    sdsrc_pix_model u_sdsrc_pix_model (
        .clk(CLK), .rst(RST), .clr(clr), .fv(fv), .lv(lv), .dk(cdark), .rrst(rrst),
        .raddr(raddr), .caddr(caddr), .rraddr(rraddr), .lv_len(lv_len), .dk_len(dk_len),
        .lines(lines), .rsts(rsts), .row0(row0), .idle(idle), .dk_first(dkf), .dk_last(dkl),
        .rr_first(rrf), .rr_second(rrs), .lv_per(lvp));

    // Clock and hang guard
    initial forever #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            final_report();
        end
    end

    // Compare and count
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Register access, one-cycle strobes
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge CLK);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge CLK);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge CLK);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(negedge CLK);
        req <= '0;
        @(negedge CLK);
        chk("reg_rdata", e, rdata);
    endtask : rd

    // One frame, ends after a long quiet time
    task automatic frame();
        @(negedge CLK);
        fs <= 1'b1;
        clr <= 1'b1;
        @(negedge CLK);
        fs <= 1'b0;
        clr <= 1'b0;
        while (idle != 12'h0c8) @(negedge CLK);
    endtask : frame

    task automatic final_report();
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (10) @(negedge CLK);
        RST <= 1'b0;
        rd(8'h21, 16'h8490);
        rd(8'h22, 16'h0107);
        rd(8'h24, 16'h8000);
        rd(8'h23, 16'h0000);
        wr(8'h21, 16'h0000);
        wr(8'h22, 16'h0300);
        rd(8'h22, 16'h0300);
        frame();
        chk("lv_len", 16'h0026, {4'h0, lv_len});
        chk("dk_len", 16'h0014, {4'h0, dk_len});
        chk("rsts", 16'h000c, {4'h0, rsts});
        chk("noise_corr", 16'h0001, {15'h0000, nce});
        chk("dk_first", 16'h0004, {4'h0, dkf});
        chk("dk_last", 16'h0017, {4'h0, dkl});
        chk("rr_first", 16'h000e, {4'h0, rrf});
        chk("lv_per", 16'h0040, {4'h0, lvp});
        wr(8'h22, 16'h0700);
        frame();
        chk("dk_len", 16'h0024, {4'h0, dk_len});
        chk("lv_len", 16'h0036, {4'h0, lv_len});
        chk("dk_last", 16'h0027, {4'h0, dkl});
        chk("lv_per", 16'h0040, {4'h0, lvp});
        wr(8'h22, 16'h00b2);
        wr(8'h24, 16'h0000);
        frame();
        chk("lines", 16'h000b, {4'h0, lines});
        chk("row0", 16'h0007, {4'h0, row0});
        chk("rsts", 16'h0008, {4'h0, rsts});
        chk("lv_len", 16'h0010, {4'h0, lv_len});
        chk("noise_corr", 16'h0000, {15'h0000, nce});
        chk("rr_first", 16'h0010, {4'h0, rrf});
        chk("lv_per", 16'h0040, {4'h0, lvp});
        wr(8'h22, 16'h0000);
        wr(8'h24, 16'h4000);
        ishort <= 1'b1;
        frame();
        chk("rsts", 16'h0010, {4'h0, rsts});
        chk("rr_first", 16'h0011, {4'h0, rrf});
        chk("rr_second", 16'h0010, {4'h0, rrs});
        ishort <= 1'b0;
        wr(8'h21, 16'h8000);
        wr(8'h22, 16'h0100);
        frame();
        chk("dk_len", 16'h0028, {4'h0, dk_len});
        chk("dk_first", 16'h0000, {4'h0, dkf});
        chk("dk_last", 16'h0027, {4'h0, dkl});
        wr(8'h22, 16'h0000);
        // Every skip code on rows and columns together
        for (int c = 0; c < 4; c++) begin
            wr(8'h21, 16'h0090 | (16'(c) << 5) | (16'(c) << 2));
            frame();
            chk("lines", (16'h0008 >> (c + 1)) | 16'(c == 3), {4'h0, lines});
            chk("lv_len", 16'h0010 >> (c + 1), {4'h0, lv_len});
        end
        ctx <= 1'b1;
        frame();
        chk("lines", 16'h0008, {4'h0, lines});
        final_report();
    end
endmodule : tb
